// ### hdl/stm_cfg.svh
/*
 * Constants of the sequential trigger matcher: widths, defaults, limits.
 * Assumes it is included by the package and the design modules by bare name.
 */
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// ============================================================
// widths and limits
`define STM_TW_MIN 1
`define STM_TW_MAX 40
`define STM_NPAT 3
`define STM_SEQ_W 2
`define STM_PCT_W 7
`define STM_CNT_W 16

// ============================================================
// defaults and reset values
`define STM_DEPTH_DEF 1024
`define STM_PCT_FULL 100
`define STM_SEQ_RST 2'h1
`define STM_REC_MAX 128

`endif

// ### hdl/stm_pkg.sv
/*
 * Types of the sequential trigger matcher.
 * Assumes stm_cfg.svh is on the include path.
 */
`include "stm_cfg.svh"

package stm_pkg;

	// ============================================================
	// one sequential trigger: three channel masks and the combine choice
	typedef struct packed {
		logic [`STM_TW_MAX-1:0] lvl;
		logic [`STM_TW_MAX-1:0] edg;
		logic [`STM_TW_MAX-1:0] dc;
		logic use_or;
	} stm_pat_t;

	// ============================================================
	// settings handed from the control clock to the sampling clock
	typedef struct packed {
		stm_pat_t [`STM_NPAT-1:0] pat;
		logic [`STM_SEQ_W-1:0] seq_len;
		logic [`STM_CNT_W-1:0] pre_n;
		logic [`STM_CNT_W-1:0] post_n;
	} stm_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE,
		ST_SEEK,
		ST_POST
	} stm_state_t;

endpackage : stm_pkg

// ### hdl/stm_pat_match.sv
/*
 * Match of one trigger pattern against the channel bus, combinational.
 * Assumes current and previous samples come from the same sampling clock.
 */
`timescale 1ns/100ps
`include "stm_cfg.svh"

module stm_pat_match
	import stm_pkg::*;
#(
	parameter int TRIG_W = `STM_TW_MAX
) (
	input wire stm_pat_t pat_in,
	input wire logic [TRIG_W-1:0] cur_in,
	input wire logic [TRIG_W-1:0] prev_in,
	output logic hit_out
);

	// ============================================================
	// per-channel condition
	wire [TRIG_W-1:0] lvl = pat_in.lvl[TRIG_W-1:0];
	wire [TRIG_W-1:0] edg = pat_in.edg[TRIG_W-1:0];
	wire [TRIG_W-1:0] care = ~pat_in.dc[TRIG_W-1:0];
	wire [TRIG_W-1:0] rise = cur_in & ~prev_in;
	wire [TRIG_W-1:0] fall = ~cur_in & prev_in;
	wire [TRIG_W-1:0] edge_ok = (lvl & rise) | (~lvl & fall);
	wire [TRIG_W-1:0] level_ok = ~(cur_in ^ lvl);
	wire [TRIG_W-1:0] bit_ok = (edg & edge_ok) | (~edg & level_ok);

	// ============================================================
	// combine
	wire all_ok = &(bit_ok | ~care);
	wire any_ok = |(bit_ok & care);
	wire no_care = ~|care;

	assign hit_out = no_care | (pat_in.use_or ? any_ok : all_ok);

endmodule : stm_pat_match

// ### hdl/stm_trig_core.sv
/*
 * Sequential trigger matcher of an embedded logic analyser.
 * Control side on core_clk_in (host debugger commands); matching on the
 * sampling clock smp_clk_in. The channel bus is user logic on smp_clk_in.
 * Settings cross by handshake: they stay frozen while busy_out is high.
 */
`timescale 1ns/100ps
`include "stm_cfg.svh"

module stm_trig_core
	import stm_pkg::*;
#(
	parameter int TRIG_W = `STM_TW_MAX,
	parameter int DEPTH = `STM_DEPTH_DEF
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic arm_in,
	input wire stm_pat_t [`STM_NPAT-1:0] pat_in,
	input wire logic [`STM_SEQ_W-1:0] seq_len_in,
	input wire logic [`STM_PCT_W-1:0] pre_pct_in,
	output logic busy_out,
	output logic done_out,
	input wire logic smp_clk_in,
	input wire logic [TRIG_W-1:0] trig_ch_in,
	output logic smp_capture_out,
	output logic smp_pre_out,
	output logic smp_trig_out,
	output logic [`STM_SEQ_W-1:0] smp_stage_out
);

	// ============================================================
	// elaboration checks
	generate
		if (TRIG_W < `STM_TW_MIN || TRIG_W > `STM_TW_MAX) begin : g_bad_w
			$error("trigger width out of range");
		end
		if (DEPTH < 1 || DEPTH >= (1 << `STM_CNT_W)) begin : g_bad_d
			$error("sample depth out of range");
		end
	endgenerate

	// ============================================================
	// helpers
	function automatic logic [`STM_CNT_W-1:0] pre_count(input logic [`STM_PCT_W-1:0] pct);
		int p;
		p = (int'(pct) > `STM_PCT_FULL) ? `STM_PCT_FULL : int'(pct);
		return `STM_CNT_W'((DEPTH * p) / `STM_PCT_FULL);
	endfunction : pre_count

	// zero would leave no pattern at all, so it reads as one
	function automatic logic [`STM_SEQ_W-1:0] seq_norm(input logic [`STM_SEQ_W-1:0] n);
		return (n == 2'h0) ? 2'h1 : n;
	endfunction : seq_norm

	// ============================================================
	// control clock domain
	stm_cfg_t cfg_q;
	logic arm_tgl_q;
	logic busy_q;
	logic done_q;
	logic done_s1_q;
	logic done_s2_q;
	logic done_s3_q;
	logic done_tgl_q;

	wire done_evt = done_s2_q ^ done_s3_q;
	// a re-arm while a capture runs is dropped: settings must not move
	wire arm_take = arm_in & ~busy_q;
	wire [`STM_CNT_W-1:0] pre_n_w = pre_count(pre_pct_in);

	stm_cfg_t cfg_d;
	always_comb begin
		cfg_d = cfg_q;
		if (arm_take) begin
			cfg_d.pat = pat_in;
			cfg_d.seq_len = seq_norm(seq_len_in);
			cfg_d.pre_n = pre_n_w;
			cfg_d.post_n = `STM_CNT_W'(DEPTH) - pre_n_w;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_q <= '0;
			arm_tgl_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			arm_tgl_q <= arm_tgl_q ^ arm_take;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			busy_q <= arm_take | (busy_q & ~done_evt);
			done_q <= done_evt | (done_q & ~arm_take);
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else begin
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end

	assign busy_out = busy_q;
	assign done_out = done_q;

	// ============================================================
	// sampling clock reset: asserted at once, released on the clock
	logic srst_s1_q;
	logic srst_n_q;

	always_ff @(posedge smp_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			srst_s1_q <= 1'b0;
			srst_n_q <= 1'b0;
		end else begin
			srst_s1_q <= 1'b1;
			srst_n_q <= srst_s1_q;
		end
	end

	// ============================================================
	// arm crossing into the sampling clock
	logic arm_s1_q;
	logic arm_s2_q;
	logic arm_s3_q;

	always_ff @(posedge smp_clk_in or negedge srst_n_q) begin
		if (!srst_n_q) begin
			arm_s1_q <= 1'b0;
			arm_s2_q <= 1'b0;
			arm_s3_q <= 1'b0;
		end else begin
			arm_s1_q <= arm_tgl_q;
			arm_s2_q <= arm_s1_q;
			arm_s3_q <= arm_s2_q;
		end
	end

	wire arm_evt = arm_s2_q ^ arm_s3_q;

	// ============================================================
	// pattern matchers
	stm_cfg_t scfg_q;
	logic [TRIG_W-1:0] prev_q;
	wire [`STM_NPAT-1:0] hit_w;

	genvar gi;
	generate
		for (gi = 0; gi < `STM_NPAT; gi++) begin : g_pat
			stm_pat_match #(
				.TRIG_W(TRIG_W)
			) u_match (
				.pat_in(scfg_q.pat[gi]),
				.cur_in(trig_ch_in),
				.prev_in(prev_q),
				.hit_out(hit_w[gi])
			);
		end
	endgenerate

	// ============================================================
	// sequence state
	stm_state_t state_q;
	stm_state_t state_d;
	logic [`STM_SEQ_W-1:0] stage_q;
	logic [`STM_SEQ_W-1:0] stage_d;
	logic [`STM_CNT_W-1:0] cnt_q;
	logic [`STM_CNT_W-1:0] cnt_d;
	logic trig_d;
	logic fin_d;
	logic smp_cap_q;
	logic smp_pre_q;
	logic smp_trig_q;

	// only the active stage is looked at, later ones wait their turn
	wire stage_hit = hit_w[stage_q];
	wire last_stage = (stage_q == scfg_q.seq_len - 2'h1);
	wire [`STM_CNT_W-1:0] cnt_inc = cnt_q + `STM_CNT_W'(1);
	wire pre_full = (cnt_inc >= scfg_q.pre_n);
	wire post_full = (cnt_inc >= scfg_q.post_n);

	always_comb begin
		state_d = state_q;
		stage_d = stage_q;
		cnt_d = cnt_q;
		trig_d = 1'b0;
		fin_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (arm_evt) begin
					stage_d = 2'h0;
					cnt_d = '0;
					state_d = (cfg_q.pre_n == '0) ? ST_SEEK : ST_PRE;
				end
			end
			ST_PRE: begin
				cnt_d = cnt_inc;
				if (pre_full) begin
					cnt_d = '0;
					state_d = ST_SEEK;
				end
			end
			ST_SEEK: begin
				if (stage_hit) begin
					if (last_stage) begin
						trig_d = 1'b1;
						cnt_d = '0;
						if (scfg_q.post_n == '0) begin
							fin_d = 1'b1;
							state_d = ST_IDLE;
						end else begin
							state_d = ST_POST;
						end
					end else begin
						stage_d = stage_q + 2'h1;
					end
				end
			end
			ST_POST: begin
				cnt_d = cnt_inc;
				if (post_full) begin
					fin_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// settings are taken only at the arm edge, while the control side holds them
	always_ff @(posedge smp_clk_in or negedge srst_n_q) begin
		if (!srst_n_q) begin
			scfg_q <= '0;
		end else if (state_q == ST_IDLE && arm_evt) begin
			scfg_q <= cfg_q;
		end
	end

	always_ff @(posedge smp_clk_in or negedge srst_n_q) begin
		if (!srst_n_q) begin
			prev_q <= '0;
		end else begin
			prev_q <= trig_ch_in;
		end
	end

	always_ff @(posedge smp_clk_in or negedge srst_n_q) begin
		if (!srst_n_q) begin
			state_q <= ST_IDLE;
			stage_q <= 2'h0;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			stage_q <= stage_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge smp_clk_in or negedge srst_n_q) begin
		if (!srst_n_q) begin
			smp_cap_q <= 1'b0;
			smp_pre_q <= 1'b0;
			smp_trig_q <= 1'b0;
			done_tgl_q <= 1'b0;
		end else begin
			smp_cap_q <= (state_d != ST_IDLE);
			smp_pre_q <= (state_d == ST_PRE) || (state_d == ST_SEEK);
			smp_trig_q <= trig_d;
			done_tgl_q <= done_tgl_q ^ fin_d;
		end
	end

	assign smp_capture_out = smp_cap_q;
	assign smp_pre_out = smp_pre_q;
	assign smp_trig_out = smp_trig_q;
	assign smp_stage_out = stage_q;

	// ============================================================
	// checks
	wire [TRIG_W-1:0] care0 = ~scfg_q.pat[0].dc[TRIG_W-1:0];
	wire [TRIG_W-1:0] edg0 = scfg_q.pat[0].edg[TRIG_W-1:0];
	wire [TRIG_W-1:0] lvl0 = scfg_q.pat[0].lvl[TRIG_W-1:0];
	// exactly one cared channel, wherever it sits on the bus
	wire one_care = (care0 != '0) && ((care0 & (care0 - TRIG_W'(1))) == '0);
	wire [TRIG_W-1:0] lvl_ok0 = care0 & ~(trig_ch_in ^ lvl0);
	wire all_dc_cur = (scfg_q.pat[stage_q].dc[TRIG_W-1:0] == {TRIG_W{1'b1}});

	arm_restart_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_IDLE && arm_evt) |=> (stage_q == 2'h0 && smp_capture_out))
		else $error("arming did not restart the sequence");

	stage_step_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_SEEK && stage_hit && !last_stage)
		|=> (stage_q == $past(stage_q) + 2'h1 && !smp_trig_out))
		else $error("stage did not advance by one");

	stage_bound_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_SEEK) |-> (stage_q < scfg_q.seq_len))
		else $error("ignored pattern became active");

	final_fire_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(smp_trig_out) |-> ($past(state_q) == ST_SEEK && $past(last_stage)
		&& $past(stage_hit) && !smp_pre_out))
		else $error("trigger without final pattern match");

	all_dc_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_SEEK && all_dc_cur) |=> (smp_trig_out || stage_q != $past(stage_q)))
		else $error("all don't-care pattern did not match at once");

	pre_len_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_PRE && cnt_inc == scfg_q.pre_n) |=> (state_q == ST_SEEK && smp_pre_out))
		else $error("pre-store length wrong");

	post_len_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(state_q == ST_POST && cnt_inc < scfg_q.post_n) |=> (state_q == ST_POST && smp_capture_out))
		else $error("post-trigger capture ended early");

	rise_bit_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(one_care && (care0 & edg0 & lvl0) != '0)
		|-> (hit_w[0] == ((care0 & trig_ch_in & ~prev_q) != '0)))
		else $error("rising edge match wrong");

	fall_bit_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(one_care && (care0 & edg0 & ~lvl0) != '0)
		|-> (hit_w[0] == ((care0 & ~trig_ch_in & prev_q) != '0)))
		else $error("falling edge match wrong");

	level_bit_a : assert property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(care0 != '0 && (care0 & edg0) == '0)
		|-> (hit_w[0] == (scfg_q.pat[0].use_or ? (lvl_ok0 != '0) : (lvl_ok0 == care0))))
		else $error("level match wrong");

	cfg_hold_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		(busy_q && !done_evt) |=> (busy_q && $stable(cfg_q)))
		else $error("settings moved during a capture");

	seq_three_c : cover property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(smp_trig_out && $past(stage_q) == 2'h2));

	or_trig_c : cover property (@(posedge smp_clk_in) disable iff (!srst_n_q)
		(smp_trig_out && scfg_q.pat[0].use_or));

	done_back_c : cover property (@(posedge core_clk_in) disable iff (!rstn_in)
		(done_evt && busy_q));

endmodule : stm_trig_core

// ### test/stm_host_model.sv
/*
 * Host debugger model: programs patterns, arms, waits for completion.
 * Assumes core clock from the bench and the trigger core's control ports.
 */
`timescale 1ns/100ps
`include "stm_cfg.svh"

module stm_host_model
	import stm_pkg::*;
#(
	parameter int TW = 8
) (
	input wire logic core_clk_in,
	input wire logic busy_in,
	input wire logic done_in,
	output logic arm_out,
	output stm_pat_t [`STM_NPAT-1:0] pat_out,
	output logic [`STM_SEQ_W-1:0] seq_len_out,
	output logic [`STM_PCT_W-1:0] pre_pct_out
);
	localparam logic [39:0] UPPER = ~((40'h1 << TW) - 40'h1);

	initial begin
		arm_out = 1'b0;
		pat_out = '0;
		seq_len_out = 2'h1;
		pre_pct_out = 7'h00;
	end

	// ============================================================
	// immediate mode: every pattern fully don't-care
	function automatic stm_pat_t [`STM_NPAT-1:0] imm();
		stm_pat_t [`STM_NPAT-1:0] p;
		p = '0;
		for (int i = 0; i < `STM_NPAT; i++) begin
			p[i].dc = '1;
		end
		return p;
	endfunction : imm

	// ============================================================
	// arm: settings held until busy is seen, never changed while busy
	task automatic go(input stm_pat_t [`STM_NPAT-1:0] p, input logic [1:0] s,
		input logic [6:0] c, output bit ok);
		int n;
		@(posedge core_clk_in);
		#1;
		for (int i = 0; i < `STM_NPAT; i++) begin
			p[i].dc = p[i].dc | UPPER;
		end
		pat_out = p;
		seq_len_out = s;
		pre_pct_out = c;
		arm_out = 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1;
			n++;
		end while (busy_in !== 1'b1 && n < 50);
		arm_out = 1'b0;
		ok = (busy_in === 1'b1);
	endtask : go

	// one capture per arm: wait for completion before any re-arm
	task automatic wait_done(output bit ok);
		int n;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1;
			n++;
		end while (done_in !== 1'b1 && n < 400);
		ok = (done_in === 1'b1) && (busy_in === 1'b0);
	endtask : wait_done
endmodule : stm_host_model

// ### test/test_sequential_trigger_matcher.sv
/*
 * Self-checking bench of the sequential trigger matcher.
 * Assumes the host model drives the control side; bench drives channels.
 */
`timescale 1ns/100ps
`include "stm_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end

module test_sequential_trigger_matcher;
	import stm_pkg::*;
	localparam int TW = 8;
	localparam int DP = 4;
	logic core_clk, smp_clk, rstn, arm, busy, done, cap, pre, trig;
	stm_pat_t [`STM_NPAT-1:0] pat;
	logic [1:0] seq, stage;
	logic [6:0] pct;
	logic [TW-1:0] ch;
	int n_fail, samples_checked, n_trig, n_pre, n_post;

	stm_host_model #(.TW(TW)) host (.core_clk_in(core_clk), .busy_in(busy), .done_in(done),
		.arm_out(arm), .pat_out(pat), .seq_len_out(seq), .pre_pct_out(pct));

	stm_trig_core #(.TRIG_W(TW), .DEPTH(DP)) DUT (.core_clk_in(core_clk), .rstn_in(rstn),
		.arm_in(arm), .pat_in(pat), .seq_len_in(seq), .pre_pct_in(pct), .busy_out(busy),
		.done_out(done), .smp_clk_in(smp_clk), .trig_ch_in(ch), .smp_capture_out(cap),
		.smp_pre_out(pre), .smp_trig_out(trig), .smp_stage_out(stage));

	// ============================================================
	// clocks and capture monitor
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		smp_clk = 1'b0;
		#1.7;
		forever #3 smp_clk = ~smp_clk;
	end
	always @(posedge smp_clk) begin
		if (trig === 1'b1) n_trig++;
		if (cap === 1'b1 && pre === 1'b1) n_pre++;
		if (cap === 1'b1 && pre === 1'b0) n_post++;
	end

	// ============================================================
	// shared tasks
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	function automatic stm_pat_t mk(input logic [39:0] l, input logic [39:0] e,
		input logic [39:0] c, input logic o);
		stm_pat_t p;
		p.lvl = l;
		p.edg = e;
		p.dc = ~c;
		p.use_or = o;
		return p;
	endfunction : mk

	task automatic drv(input logic [TW-1:0] v);
		@(posedge smp_clk);
		#1 ch = v;
	endtask : drv

	task automatic idle(input int k);
		repeat (k) @(posedge smp_clk);
		#1;
	endtask : idle

	// sel 0 trigger pulse, 1 second stage, 2 capture start
	task automatic wait_for(input int sel, input int lim, output int n);
		n = 0;
		while (!(sel == 0 ? trig === 1'b1 : sel == 1 ? stage === 2'h1 : cap === 1'b1)
			&& n < lim) begin
			@(posedge smp_clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			n_fail++;
			$display("wrong value timeout %0d exp 1 got 0", sel);
			finish_test();
		end
	endtask : wait_for

	task automatic start(input stm_pat_t [`STM_NPAT-1:0] p, input logic [1:0] s,
		input logic [6:0] c);
		bit ok;
		int n;
		n_trig = 0;
		n_pre = 0;
		n_post = 0;
		host.go(p, s, c, ok);
		`CHK("arm taken", 1'b1, ok)
		if (!ok) finish_test();
		`CHK("done cleared", 1'b0, done)
		wait_for(2, 60, n);
		`CHK("stage at arm", 2'h0, stage)
	endtask : start

	task automatic stop(input string nm);
		bit ok;
		host.wait_done(ok);
		`CHK("done", 1'b1, ok)
		if (!ok) finish_test();
		`CHK("one trigger", 1, n_trig)
		$display("test %s finished", nm);
	endtask : stop

	task automatic edge_run(input string nm, input stm_pat_t p, input logic [TW-1:0] v0,
		input logic [TW-1:0] v1, input logic [TW-1:0] v2, input logic [1:0] s);
		stm_pat_t [`STM_NPAT-1:0] ps;
		int n;
		ps = host.imm();
		ps[0] = p;
		drv(v0);
		start(ps, s, 7'h00);
		idle(5);
		drv(v1);
		idle(4);
		`CHK("no early trigger", 0, n_trig)
		drv(v2);
		wait_for(0, 6, n);
		`CHK("edge trigger delay", 1'b1, n <= 2)
		stop(nm);
	endtask : edge_run

	// ============================================================
	// scenarios
	task automatic t_imm();
		int pr[3] = '{0, 2, 4};
		logic [6:0] pc[3] = '{7'h00, 7'h32, 7'h7F};
		for (int i = 0; i < 3; i++) begin
			start(host.imm(), 2'h3, pc[i]);
			stop("immediate");
			`CHK("pre samples", pr[i] + 3, n_pre)
			`CHK("post samples", DP - pr[i], n_post)
		end
	endtask : t_imm

	task automatic t_rise();
		edge_run("rise", mk(40'h01, 40'h01, 40'h01, 1'b0), 8'h01, 8'hFE, 8'hFF, 2'h1);
	endtask : t_rise

	task automatic t_fall();
		edge_run("fall", mk(40'h00, 40'h80, 40'h80, 1'b1), 8'h00, 8'h80, 8'h7F, 2'h0);
	endtask : t_fall

	task automatic t_seq();
		stm_pat_t [`STM_NPAT-1:0] ps;
		int n;
		ps[0] = mk(40'h06, 40'h00, 40'h06, 1'b1);
		ps[1] = mk(40'h10, 40'h00, 40'h18, 1'b0);
		ps[2] = mk(40'h20, 40'h20, 40'h20, 1'b0);
		drv(8'h00);
		start(ps, 2'h2, 7'h00);
		drv(8'h18);
		idle(4);
		`CHK("stage held", 2'h0, stage)
		drv(8'h04);
		wait_for(1, 4, n);
		drv(8'h1C);
		idle(4);
		`CHK("partial and", 0, n_trig)
		`CHK("stage kept", 2'h1, stage)
		drv(8'h14);
		wait_for(0, 4, n);
		`CHK("sequence trigger delay", 1'b1, n <= 2)
		stop("sequence");
	endtask : t_seq

	initial begin
		rstn = 1'b0;
		ch = '0;
		n_fail = 0;
		samples_checked = 0;
		repeat (20) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge core_clk);
		t_imm();
		t_rise();
		t_fall();
		t_seq();
		finish_test();
	end
endmodule : test_sequential_trigger_matcher
